// *** pkg/spi_port_pkg.sv ***
// constants shared by the serial peripheral port design
// Notes on behaviour
// - master drives output line from shift MSB
// - input line floats when disabled or deselected
// - 3-wire slave always drives shift MSB out
// - master makes clock; deselected slave ignores it
// - select field 00: 3-wire, always selected
// - select field 01: select is an input
// - select field 1x: select output follows low bit
// - select pin unmapped only in 3-wire form
// - master enable; data write loads transmit buffer
// - empty shifter takes buffer and starts shifting
// - transfer done flag set each finished byte
// - received bits MSB first into receive buffer
// - field 01 master is multi-master mode
// - low select in multi-master faults and disables
// - field 00 master: 3-wire single master
// - high field bit: 4-wire single master output
// - write while buffer full flags collision, dropped
// - busy held through every master transfer; slave busy only from first to last sampling edge
// - bit rate capped at quarter clock, 12.5 MHz
// - both ends share polarity and phase setting
package spi_port_pkg;
	localparam int BYTE_W = 8;
	// select mode field encodings
	localparam logic [1:0] SEL_3WIRE = 2'h0;
	localparam logic [1:0] SEL_MULTI = 2'h1;
	// edge index of the last of sixteen clock half periods
	localparam logic [3:0] LAST_EDGE = 4'hF;
	// link bit counter value on the last bit of a byte
	localparam logic [2:0] LAST_BIT = 3'h7;
	// timing: system clock and the bit rate cap
	localparam longint MCLK_HZ = 50_000_000;
	localparam longint MAX_SCK_HZ = 12_500_000;
	// least half period in clocks, rounded up
	localparam int MIN_HALF_CYC = int'((MCLK_HZ + 2 * MAX_SCK_HZ - 1) / (2 * MAX_SCK_HZ));
	// reset values
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic TX_EMPTY_RST = 1'b1;
endpackage

// *** core/bit_sync.sv ***
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_q; // first stage, read only by second

	////////////////////////////////////////////////////////////////
	// both stages; each bit crosses alone, so no word coherence
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= '0;
			q_out <= '0;
		end else begin
			meta_q <= d_in;
			q_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// *** core/serial_peripheral_port.sv ***
// serial peripheral port: master engine, slave link logic, pin control
`timescale 1ns/1ps
`default_nettype none
module serial_peripheral_port #(
	parameter int DIV_W = 8
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// software control pulses
	input wire logic port_enable_set_in,
	input wire logic port_enable_clr_in,
	input wire logic master_enable_set_in,
	input wire logic master_enable_clr_in,
	input wire logic transfer_done_clr_in,
	input wire logic write_collision_clr_in,
	input wire logic mode_fault_clr_in,
	input wire logic rx_overrun_clr_in,
	// configuration levels
	input wire logic clock_polarity_in,
	input wire logic clock_phase_in,
	input wire logic [1:0] select_mode_in,
	input wire logic [DIV_W-1:0] clock_divider_in,
	// data access
	input wire logic data_wr_in,
	input wire logic [7:0] data_wr_byte_in,
	input wire logic data_rd_in,
	output logic [7:0] rx_byte_out,
	// status
	output logic port_enable_out,
	output logic master_enable_out,
	output logic busy_out,
	output logic tx_buffer_empty_out,
	output logic transfer_done_flag_out,
	output logic write_collision_flag_out,
	output logic mode_fault_flag_out,
	output logic rx_overrun_flag_out,
	output logic slave_selected_out,
	// bus pins
	input wire logic sck_link_in,
	output logic sck_out,
	output logic sck_oe_out,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_out,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_out,
	input wire logic nss_in,
	output logic nss_out,
	output logic nss_oe_out,
	output logic nss_mapped_out
);
	localparam int BW = spi_port_pkg::BYTE_W;

	// control state
	logic en_q; // port enable
	logic master_q; // master enable
	logic [BW-1:0] tx_buf_q; // transmit buffer
	logic tx_full_q;
	logic [BW-1:0] rx_q; // receive buffer
	logic rx_full_q; // unread byte held
	logic done_q, write_collision_flag_q, mode_fault_flag_q, ovr_q;

	// master engine
	logic run_q; // master shifting
	logic sck_q; // generated serial clock
	logic [3:0] edge_q; // half period index
	logic [DIV_W:0] hp_q; // clocks within half period
	logic [BW-1:0] sh_q; // master shift register
	logic rx_bit_q; // sampled input bit
	logic [DIV_W:0] half_cyc; // clocks per half period
	logic tick; // half period ends
	logic sample_now, shift_now;
	logic m_done; // master byte finished
	logic [BW-1:0] m_byte; // master byte as received

	// synchronised pins and link signals
	logic [1:0] pin_s;
	logic miso_s, nss_s;
	logic [1:0] link_s;
	logic done_seen_q; // last seen link toggle
	logic s_done; // slave byte finished
	logic link_busy_s;

	// link domain
	logic lclk; // link clock, sampling edge rising
	logic link_rst_n;
	logic [2:0] cnt_l; // bit counter
	logic [BW-1:0] rsh_l; // receive shift
	logic [BW-1:0] tsh_l; // transmit shift
	logic [BW-1:0] byte_l; // last complete byte
	logic done_tog_l; // toggles per byte
	logic busy_l;
	logic [BW-1:0] stx_q; // slave byte to send, mclk side

	// decoded modes
	logic slave_act, fault, sel_in_mode, sel_3w;
	logic master_load, slave_take, wr_ok;

	////////////////////////////////////////////////////////////////
	// pin and link synchronisers

	// pins from the bus are asynchronous to mclk
	bit_sync #(.W(2)) u_pin_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.d_in({miso_in, nss_in}),
		.q_out(pin_s)
	);
	assign miso_s = pin_s[1];
	assign nss_s = pin_s[0];

	// byte event toggle and busy level from the link clock
	bit_sync #(.W(2)) u_link_sync (
		.clk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.d_in({done_tog_l, busy_l}),
		.q_out(link_s)
	);
	assign link_busy_s = link_s[0];
	assign s_done = link_s[1] ^ done_seen_q;

	// toggle edge detector
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_seen_q <= 1'b0;
		end else begin
			done_seen_q <= link_s[1];
		end
	end

	////////////////////////////////////////////////////////////////
	// mode decode

	assign sel_3w = (select_mode_in == spi_port_pkg::SEL_3WIRE);
	assign sel_in_mode = (select_mode_in == spi_port_pkg::SEL_MULTI);
	assign slave_act = en_q & ~master_q;
	// another master pulled select low
	assign fault = en_q & master_q & sel_in_mode & ~nss_s;
	assign slave_selected_out = slave_act & (sel_3w | (sel_in_mode & ~nss_s));

	////////////////////////////////////////////////////////////////
	// enables: fault wins over software set

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en_q <= 1'b0;
			master_q <= 1'b0;
		end else if (fault) begin
			en_q <= 1'b0;
			master_q <= 1'b0;
		end else begin
			if (port_enable_set_in) begin
				en_q <= 1'b1;
			end else if (port_enable_clr_in) begin
				en_q <= 1'b0;
			end
			if (master_enable_set_in) begin
				master_q <= 1'b1;
			end else if (master_enable_clr_in) begin
				master_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// transmit buffer

	assign wr_ok = data_wr_in & ~tx_full_q;
	assign master_load = master_q & en_q & ~run_q & tx_full_q;
	// slave takes a byte between bytes or when idle
	assign slave_take = slave_act & tx_full_q & (~link_busy_s | s_done);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_full_q <= ~spi_port_pkg::TX_EMPTY_RST;
			tx_buf_q <= spi_port_pkg::BYTE_RST;
			stx_q <= spi_port_pkg::BYTE_RST;
		end else begin
			if (wr_ok) begin
				tx_buf_q <= data_wr_byte_in;
				tx_full_q <= 1'b1;
			end else if (master_load | slave_take) begin
				tx_full_q <= 1'b0;
			end
			if (slave_take) begin
				stx_q <= tx_buf_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// master clock timing

	// divider, floored at the least legal half period
	always_comb begin
		half_cyc = {1'b0, clock_divider_in} + 1'b1;
		if (half_cyc < (DIV_W+1)'(spi_port_pkg::MIN_HALF_CYC)) begin
			half_cyc = (DIV_W+1)'(spi_port_pkg::MIN_HALF_CYC);
		end
	end
	assign tick = run_q & (hp_q == half_cyc - 1'b1);
	// even edges lead, odd edges trail
	assign sample_now = (edge_q[0] == clock_phase_in);
	assign shift_now = (edge_q[0] != clock_phase_in) & (edge_q != 4'h0);
	assign m_done = tick & (edge_q == spi_port_pkg::LAST_EDGE);
	assign m_byte = {sh_q[BW-2:0], clock_phase_in ? miso_s : rx_bit_q};

	// run flag, half period count and the clock itself
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_q <= 1'b0;
			sck_q <= 1'b0;
			edge_q <= 4'h0;
			hp_q <= '0;
		end else if (!(master_q & en_q) | !run_q) begin
			sck_q <= clock_polarity_in;
			edge_q <= 4'h0;
			hp_q <= '0;
			run_q <= master_load;
		end else if (tick) begin
			hp_q <= '0;
			sck_q <= ~sck_q;
			edge_q <= edge_q + 4'h1;
			if (edge_q == spi_port_pkg::LAST_EDGE) begin
				run_q <= 1'b0;
			end
		end else begin
			hp_q <= hp_q + 1'b1;
		end
	end

	// master data: sample on one edge, shift on the other
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sh_q <= spi_port_pkg::BYTE_RST;
			rx_bit_q <= 1'b0;
		end else if (master_load) begin
			sh_q <= tx_buf_q;
		end else if (tick) begin
			if (sample_now) begin
				rx_bit_q <= miso_s;
			end
			if (m_done) begin
				sh_q <= m_byte;
			end else if (shift_now) begin
				sh_q <= {sh_q[BW-2:0], rx_bit_q};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// receive buffer and flags; hardware set wins over clear

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_q <= spi_port_pkg::BYTE_RST;
			rx_full_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			if (m_done) begin
				rx_q <= m_byte;
				rx_full_q <= 1'b1;
			end else if (s_done & rx_full_q & ~data_rd_in) begin
				ovr_q <= 1'b1; // new byte lost, old one kept
			end else if (s_done) begin
				rx_q <= byte_l;
				rx_full_q <= 1'b1;
			end else if (data_rd_in) begin
				rx_full_q <= 1'b0;
			end
			if (rx_overrun_clr_in & ~(s_done & rx_full_q & ~data_rd_in)) begin
				ovr_q <= 1'b0;
			end
		end
	end

	// sticky event flags
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			mode_fault_flag_q <= 1'b0;
		end else begin
			done_q <= (m_done | s_done) | (done_q & ~transfer_done_clr_in);
			write_collision_flag_q <= (data_wr_in & tx_full_q) | (write_collision_flag_q & ~write_collision_clr_in);
			mode_fault_flag_q <= fault | (mode_fault_flag_q & ~mode_fault_clr_in);
		end
	end

	////////////////////////////////////////////////////////////////
	// slave link domain, clocked by the bus clock

	// remap so the sampling edge is always rising; config static while enabled
	assign lclk = sck_link_in ^ (clock_polarity_in ^ clock_phase_in);
	// deselect holds the counter in reset so clock is ignored
	assign link_rst_n = rst_n_in & slave_act & (sel_3w | (sel_in_mode & ~nss_in));

	// bit counter and receive shift
	always_ff @(posedge lclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cnt_l <= 3'h0;
			rsh_l <= spi_port_pkg::BYTE_RST;
			busy_l <= 1'b0;
		end else begin
			cnt_l <= cnt_l + 3'h1;
			rsh_l <= {rsh_l[BW-2:0], mosi_in};
			busy_l <= (cnt_l != spi_port_pkg::LAST_BIT);
		end
	end

	// completed byte and its event toggle survive deselect
	always_ff @(posedge lclk or negedge rst_n_in) begin
		if (!rst_n_in) begin
			byte_l <= spi_port_pkg::BYTE_RST;
			done_tog_l <= 1'b0;
		end else if (link_rst_n & (cnt_l == spi_port_pkg::LAST_BIT)) begin
			byte_l <= {rsh_l[BW-2:0], mosi_in};
			done_tog_l <= ~done_tog_l;
		end
	end

	// transmit shift on the opposite edge
	always_ff @(negedge lclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tsh_l <= spi_port_pkg::BYTE_RST;
		end else if (cnt_l == 3'h1) begin
			tsh_l <= {stx_q[BW-2:0], 1'b0};
		end else begin
			tsh_l <= {tsh_l[BW-2:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////
	// pins and status

	assign sck_out = sck_q;
	assign sck_oe_out = master_q & en_q;
	assign mosi_out = sh_q[BW-1];
	assign mosi_oe_out = master_q & en_q;
	// first bit of a byte comes straight from the held byte
	assign miso_out = (cnt_l == 3'h0) ? stx_q[BW-1] : tsh_l[BW-1];
	assign miso_oe_out = slave_selected_out;
	assign nss_out = select_mode_in[0];
	assign nss_oe_out = select_mode_in[1];
	assign nss_mapped_out = ~sel_3w;
	assign port_enable_out = en_q;
	assign master_enable_out = master_q;
	assign busy_out = run_q | (slave_act & link_busy_s);
	assign tx_buffer_empty_out = ~tx_full_q;
	assign rx_byte_out = rx_q;
	assign transfer_done_flag_out = done_q;
	assign write_collision_flag_out = write_collision_flag_q;
	assign mode_fault_flag_out = mode_fault_flag_q;
	assign rx_overrun_flag_out = ovr_q;

	////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	chk_load_msb: assert property (master_load |=> mosi_out == $past(tx_buf_q[BW-1]))
		else $error("master output not from loaded MSB");
	chk_miso_float: assert property (!en_q || (master_q && !sel_3w) |-> !miso_oe_out)
		else $error("input line driven while idle");
	chk_miso_3wire: assert property (slave_act && sel_3w |-> miso_oe_out)
		else $error("3-wire slave not driving");
	chk_sck_idle: assert property (!run_q && $past(!run_q) && $stable(clock_polarity_in) |-> sck_out == clock_polarity_in)
		else $error("clock not idle at polarity");
	chk_fault_off: assert property (fault |=> !en_q && !master_q && mode_fault_flag_out)
		else $error("mode fault did not disable");
	chk_write_collision_flag_drop: assert property (data_wr_in && tx_full_q |=> write_collision_flag_out && $stable(tx_buf_q))
		else $error("collision write not dropped");
	chk_done_byte: assert property (m_done |=> transfer_done_flag_out && rx_byte_out == $past(m_byte))
		else $error("done byte not captured");
	chk_busy_run: assert property (run_q |-> busy_out)
		else $error("busy low during transfer");
	chk_run_len: assert property (master_load |=> run_q[*8])
		else $error("transfer ended early");
	chk_half_min: assert property (run_q && $past(run_q) && $changed(sck_q) |=> $stable(sck_q))
		else $error("half period below two clocks");
endmodule
`default_nettype wire

// *** verification/spi_far_end.sv ***
// far side model: a slave for the master engine and a master for the slave link
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
	input wire logic sck_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic [7:0] got_out,
	output logic link_sck_out,
	output logic link_mosi_out,
	output logic nss_n_out,
	input wire logic link_miso_in
);
	logic [7:0] base; // reply byte of the current frame
	logic [7:0] sh; // reply shifter
	int n; // bits already sent
	////////////////////////////////////////////////////////////////
	// slave side: sole slave on the bus, mode 0 timing as the master
	initial begin
		link_sck_out = 1'b0;
		link_mosi_out = 1'b0;
		nss_n_out = 1'b1;
		base = 8'h00;
		sh = 8'h00;
		n = 0;
	end
	assign miso_out = sh[7];
	// capture on the leading edge
	always @(posedge sck_in) begin
		got_out <= {got_out[6:0], mosi_in};
	end
	// next bit on the trailing edge; each later byte replies the inverse
	always @(negedge sck_in) begin
		if (n == 7) begin
			base = ~base;
			sh = base;
			n = 0;
		end else begin
			sh = sh << 1;
			n++;
		end
	end
	// prime the reply before a master run
	task automatic arm(input logic [7:0] b);
		base = b;
		sh = b;
		n = 0;
	endtask
	////////////////////////////////////////////////////////////////
	// master side: 80 ns link clock, only inside frames; ph picks the launch edge
	task automatic select(input logic v);
		nss_n_out = v;
	endtask
	task automatic send(input logic [7:0] tx, input logic ph, output logic [7:0] rx);
		#7;
		nss_n_out = 1'b0;
		#200;
		for (int i = 7; i >= 0; i--) begin
			// phase 0 launches before the rising edge and samples on it
			if (!ph) begin
				link_mosi_out = tx[i];
			end
			#40 link_sck_out = 1'b1;
			if (ph) begin
				link_mosi_out = tx[i];
			end else begin
				rx[i] = link_miso_in;
			end
			#40 link_sck_out = 1'b0;
			// phase 1 samples on the falling edge, before the slave moves on
			if (ph) begin
				rx[i] = link_miso_in;
			end
		end
		#100;
		// released line: no stale value left behind
		link_mosi_out = ~link_mosi_out;
		nss_n_out = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk, rst_n, cpol, cpha, data_wr, data_rd, done_prev;
	logic [7:0] ctl, wbyte, div, rx_seen, r, t;
	logic [1:0] sel;
	logic [31:0] seed; // random source
	logic [7:0] exp_q[$]; // expected received bytes
	int err_total, checked, cyc;
	logic [7:0] rx_byte_out, got;
	logic pe, me, busy, txe, done, write_collision_flag, mode_fault_flag, ovr, selected;
	logic sck, sck_oe, mosi, mosi_oe, miso_s, miso, miso_oe, slave_select_n, nss_oe, nss_map;
	logic lsck, lmosi, lnss;
	serial_peripheral_port i_serial_peripheral_port (.mclk_in(mclk), .rst_n_in(rst_n),
		.port_enable_set_in(ctl[0]), .port_enable_clr_in(ctl[1]), .master_enable_set_in(ctl[2]),
		.master_enable_clr_in(ctl[3]), .transfer_done_clr_in(ctl[4]), .write_collision_clr_in(ctl[5]),
		.mode_fault_clr_in(ctl[6]), .rx_overrun_clr_in(ctl[7]), .clock_polarity_in(cpol),
		.clock_phase_in(cpha), .select_mode_in(sel), .clock_divider_in(div), .data_wr_in(data_wr),
		.data_wr_byte_in(wbyte), .data_rd_in(data_rd), .rx_byte_out(rx_byte_out), .port_enable_out(pe),
		.master_enable_out(me), .busy_out(busy), .tx_buffer_empty_out(txe), .transfer_done_flag_out(done),
		.write_collision_flag_out(write_collision_flag), .mode_fault_flag_out(mode_fault_flag), .rx_overrun_flag_out(ovr),
		.slave_selected_out(selected), .sck_link_in(lsck), .sck_out(sck), .sck_oe_out(sck_oe),
		.mosi_in(lmosi), .mosi_out(mosi), .mosi_oe_out(mosi_oe), .miso_in(miso_s), .miso_out(miso),
		.miso_oe_out(miso_oe), .nss_in(lnss), .nss_out(slave_select_n), .nss_oe_out(nss_oe), .nss_mapped_out(nss_map));
	spi_far_end i_spi_far_end (.sck_in(sck), .mosi_in(mosi), .miso_out(miso_s), .got_out(got),
		.link_sck_out(lsck), .link_mosi_out(lmosi), .nss_n_out(lnss), .link_miso_in(miso_oe ? miso : 1'bz));
	////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end
	// each finished byte takes the oldest note
	always @(posedge mclk) begin
		done_prev <= done;
		if (done === 1'b1 && done_prev !== 1'b1) begin
			rx_seen = exp_q.size() ? exp_q.pop_front() : 8'hXX;
			chk("rx_byte", rx_byte_out, rx_seen);
		end
	end
	////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic pulse(input logic [7:0] m);
		ctl = m;
		@(posedge mclk) #1 ctl = 8'h00;
		@(posedge mclk) #1;
	endtask
	task automatic wr(input logic [7:0] b);
		data_wr = 1'b1;
		wbyte = b;
		@(posedge mclk) #1 data_wr = 1'b0;
		@(posedge mclk) #1;
	endtask
	task automatic wait_done();
		int k;
		k = 0;
		while (done !== 1'b1 && k < 3000) begin
			@(posedge mclk);
			k++;
		end
		chk("done_wait", {7'h00, done}, 8'h01);
		#1 pulse(8'h10);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst_n, cpol, cpha, data_wr, data_rd, ctl, wbyte, div, sel} = '0;
		seed = 32'h0000AF2D;
		repeat (8) @(posedge mclk);
		#1 rst_n = 1'b1;
		@(posedge mclk) #1;
		chk("status", {pe, me, busy, txe, done, write_collision_flag, mode_fault_flag, sck}, 8'h10);
		chk("miso_oe_off", {7'h00, miso_oe}, 8'h00);
		// 3-wire master, back-to-back bytes and a collision
		div = 8'h04;
		pulse(8'h05);
		chk("pins_master", {3'h0, sck_oe, mosi_oe, miso_oe, nss_oe, nss_map}, 8'h18);
		seed = lfsr(seed);
		r = seed[7:0];
		i_spi_far_end.arm(r);
		exp_q.push_back(r);
		exp_q.push_back(~r);
		seed = lfsr(seed);
		t = seed[15:8];
		wr(seed[7:0]);
		repeat (2) @(posedge mclk);
		#1 chk("busy", {7'h00, busy}, 8'h01);
		chk("tx_moved", {7'h00, txe}, 8'h01);
		wr(t);
		wr(8'hA5);
		chk("collision", {7'h00, write_collision_flag}, 8'h01);
		wait_done();
		chk("far_got1", got, seed[7:0]);
		wait_done();
		chk("far_got2", got, t);
		pulse(8'h20);
		chk("idle", {6'h00, busy, write_collision_flag}, 8'h00);
		// read the master bytes so the slave byte is not an overrun
		data_rd = 1'b1;
		@(posedge mclk) #1 data_rd = 1'b0;
		// select output follows the low field bit
		for (int i = 2; i < 4; i++) begin
			sel = i[1:0];
			@(posedge mclk) #1;
			chk("nss_out", {5'h00, nss_oe, slave_select_n, nss_map}, {5'h00, 1'b1, i[0], 1'b1});
		end
		// multi-master: select low faults and disables
		sel = 2'h1;
		i_spi_far_end.select(1'b0);
		repeat (5) @(posedge mclk);
		#1 chk("fault", {5'h00, pe, me, mode_fault_flag}, 8'h01);
		// re-enabling while select is still low faults again at once
		pulse(8'h05);
		chk("fault_again", {5'h00, pe, me, mode_fault_flag}, 8'h01);
		i_spi_far_end.select(1'b1);
		repeat (4) @(posedge mclk);
		#1 pulse(8'h40);
		// 4-wire slave
		pulse(8'h01);
		chk("slave_unsel", {6'h00, selected, miso_oe}, 8'h00);
		seed = lfsr(seed);
		wr(seed[15:8]);
		exp_q.push_back(seed[7:0]);
		i_spi_far_end.send(seed[7:0], 1'b0, r);
		chk("slave_tx", r, seed[15:8]);
		wait_done();
		pulse(8'h00);
		data_rd = 1'b1;
		@(posedge mclk) #1 data_rd = 1'b0;
		// 3-wire slave: always selected and driving
		sel = 2'h0;
		repeat (3) @(posedge mclk);
		#1 chk("slave3", {6'h00, selected, miso_oe}, 8'h03);
		seed = lfsr(seed);
		wr(seed[7:0]);
		exp_q.push_back(seed[15:8]);
		i_spi_far_end.send(seed[15:8], 1'b0, r);
		chk("slave3_tx", r, seed[7:0]);
		wait_done();
		chk("overrun", {7'h00, ovr}, 8'h00);
		// phase 1 link; the unread byte is kept when the next one lands
		t = seed[15:8];
		pulse(8'h02);
		cpha = 1'b1;
		pulse(8'h01);
		seed = lfsr(seed);
		wr(seed[7:0]);
		exp_q.push_back(t);
		i_spi_far_end.send(seed[15:8], 1'b1, r);
		chk("phase1_tx", r, seed[7:0]);
		wait_done();
		chk("overrun_set", {7'h00, ovr}, 8'h01);
		data_rd = 1'b1;
		@(posedge mclk) #1 data_rd = 1'b0;
		pulse(8'h80);
		chk("overrun_clr", {7'h00, ovr}, 8'h00);
		exp_q.push_back(seed[7:0]);
		i_spi_far_end.send(seed[7:0], 1'b1, r);
		wait_done();
		// master clock idles at the polarity level
		pulse(8'h05);
		cpol = 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk("sck_idle", {7'h00, sck}, 8'h01);
		chk("pending", exp_q.size(), 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
